// file: rtl/resp_pkg.sv
// shared constants and carriers for the not-ready / error responder
package resp_pkg;
    // ------------------------------------------------------------
    // command operation codes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_TUR = 8'h00;
    localparam logic [7:0] OP_RSENSE = 8'h03;
    localparam logic [7:0] OP_INQ = 8'h12;
    localparam logic [7:0] OP_SSU = 8'h1b;
    localparam logic [7:0] OP_RLUNS = 8'ha0;
    // ------------------------------------------------------------
    // status, sense keys, response codes
    // ------------------------------------------------------------
    localparam logic [7:0] ST_GOOD = 8'h00;
    localparam logic [7:0] ST_CHECK = 8'h02;
    localparam logic [3:0] SK_NONE = 4'h0;
    localparam logic [3:0] SK_NOT_READY = 4'h2;
    localparam logic [3:0] SK_MEDIUM = 4'h3;
    localparam logic [3:0] SK_HARDWARE = 4'h4;
    localparam logic [3:0] SK_ILLEGAL = 4'h5;
    localparam logic [7:0] RC_CUR_FIX = 8'h70;
    localparam logic [7:0] RC_DEF_FIX = 8'h71;
    localparam logic [7:0] RC_CUR_DSC = 8'h72;
    localparam logic [7:0] RC_DEF_DSC = 8'h73;
    // ------------------------------------------------------------
    // additional sense code and qualifier pairs
    // ------------------------------------------------------------
    localparam logic [15:0] ASC_NONE = 16'h0000;
    localparam logic [15:0] ASC_SPIN_FAIL = 16'h0400;
    localparam logic [15:0] ASC_BECOMING = 16'h0401;
    localparam logic [15:0] ASC_INIT_REQ = 16'h0402;
    localparam logic [15:0] ASC_FMT_PROG = 16'h0404;
    localparam logic [15:0] ASC_BAD_CDB = 16'h2400;
    localparam logic [15:0] ASC_BRINGUP = 16'h4080;
    localparam logic [15:0] ASC_RAM_LOAD = 16'h4085;
    localparam logic [15:0] ASC_INTERNAL = 16'h4400;
    localparam logic [15:0] ASC_FMT_BAD = 16'h3100;
    localparam logic [15:0] ASC_WR_ERR = 16'h0c00;
    // ------------------------------------------------------------
    // start outcome codes, mode page bit location
    // ------------------------------------------------------------
    localparam logic [1:0] SR_OK = 2'h0;
    localparam logic [1:0] SR_SPIN = 2'h1;
    localparam logic [1:0] SR_BRINGUP = 2'h2;
    localparam logic [1:0] SR_RAMLOAD = 2'h3;
    localparam int MP0_FDD_BYTE = 5;
    localparam int MP0_FDD_BIT = 4;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_PROG = 8'h04;
    localparam logic [7:0] A_EVENT = 8'h08;
    localparam logic [7:0] A_STAT = 8'h0c;
    localparam logic [7:0] A_LAST = 8'h10;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] start_result;
        logic desc_sense;
        logic write_cache_on_bit;
        logic format_degrade_disable_bit;
        logic autostart_en;
        logic format_act;
        logic startup_act;
    } ctrl_t;
    localparam ctrl_t CTRL_RST = 8'h00;
    localparam logic [15:0] PROG_RST = 16'h0000;
    typedef struct packed {
        logic fmt_ok;
        logic wce_write_err;
        logic imm_fmt_err;
        logic fmt_fail;
        logic cfg_rev_mismatch;
        logic cfg_read_fail;
        logic stop_done;
        logic selfcfg_ok;
        logic spin_fail;
        logic spin_start;
        logic autostart_abort;
    } ev_t;
    typedef struct packed {
        logic exec;
        logic [7:0] status;
        logic [7:0] code;
        logic [3:0] key;
        logic [15:0] asc;
        logic [15:0] prog;
    } rsp_t;
endpackage : resp_pkg

// file: rtl/pending_table.sv
// per-initiator pending internal error flags
module pending_table #(
    parameter int NI = 64,
    parameter int IW = 6
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // set for all, clear for one
    input wire logic set_all,
    input wire logic clr,
    input wire logic [IW-1:0] clr_idx,
    // flag view
    output logic [NI-1:0] pend
);
    logic [NI-1:0] pend_q;
    logic [NI-1:0] clr_mask;
    logic [NI-1:0] pend_d;

    // a new error for everyone beats a clear in the same cycle
    assign clr_mask = clr ? (NI'(1) << clr_idx) : '0;
    assign pend_d = (pend_q & ~clr_mask) | {NI{set_all}};
    assign pend = pend_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            pend_q <= '0;
        end else begin
            pend_q <= pend_d;
        end
    end
endmodule : pending_table

// file: rtl/apb_regs.sv
// apb register file for the responder
module apb_regs (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // block side
    output resp_pkg::ctrl_t ctrl,
    output logic [15:0] prog,
    output resp_pkg::ev_t ev,
    input wire logic [31:0] stat_w,
    input wire logic [31:0] last_w
);
    resp_pkg::ctrl_t ctrl_q;
    logic [15:0] prog_q;
    logic acc, wr, hit;

    // decode; every access completes at once
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign hit = paddr == resp_pkg::A_CTRL || paddr == resp_pkg::A_PROG
        || paddr == resp_pkg::A_EVENT || paddr == resp_pkg::A_STAT
        || paddr == resp_pkg::A_LAST;
    assign pready = 1'b1;
    assign pslverr = acc && !hit;
    // event bits are one-cycle pulses, never stored here
    assign ev = (wr && paddr == resp_pkg::A_EVENT) ? resp_pkg::ev_t'(pwdata[10:0]) : '0;
    assign ctrl = ctrl_q;
    assign prog = prog_q;
    assign prdata = !hit ? 32'h0000_0000
        : paddr == resp_pkg::A_CTRL ? {24'h000000, ctrl_q}
        : paddr == resp_pkg::A_PROG ? {16'h0000, prog_q}
        : paddr == resp_pkg::A_STAT ? stat_w
        : paddr == resp_pkg::A_LAST ? last_w : 32'h0000_0000;

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= resp_pkg::CTRL_RST;
            prog_q <= resp_pkg::PROG_RST;
        end else begin
            if (wr && paddr == resp_pkg::A_CTRL) ctrl_q <= resp_pkg::ctrl_t'(pwdata[7:0]);
            if (wr && paddr == resp_pkg::A_PROG) prog_q <= pwdata[15:0];
        end
    end
endmodule : apb_regs

// file: rtl/not_ready_responder.sv
// command responder for startup, format, internal error, deferred and degraded states
//
// The APB register port and the register offsets were left to the implementer.
module not_ready_responder #(
    parameter int NI = 64,
    parameter int IW = 6
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic SRST,
    // apb register bus
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // received command
    input wire logic CMD_VALID,
    input wire logic [IW-1:0] CMD_INIT,
    input wire logic [7:0] CMD_OPCODE,
    input wire logic CMD_VITAL_PRODUCT_PAGE_REQUEST,
    input wire logic CMD_START,
    // decided response
    output logic RSP_VALID,
    output logic RSP_EXEC,
    output logic [7:0] RSP_STATUS,
    output logic [7:0] RSP_CODE,
    output logic [3:0] RSP_KEY,
    output logic [15:0] RSP_ASC,
    output logic [15:0] RSP_PROG
);
    // ------------------------------------------------------------
    // registers and condition table
    // ------------------------------------------------------------
    resp_pkg::ctrl_t ctrl;
    resp_pkg::ev_t ev;
    logic [15:0] prog;
    logic [NI-1:0] pend;
    logic [31:0] stat_w, last_w;
    logic clr_ie, clr_def;

    apb_regs u_regs (
        .clk(MCLK),
        .rst(SRST),
        .psel(PSEL),
        .penable(PENABLE),
        .pwrite(PWRITE),
        .paddr(PADDR),
        .pwdata(PWDATA),
        .prdata(PRDATA),
        .pready(PREADY),
        .pslverr(PSLVERR),
        .ctrl(ctrl),
        .prog(prog),
        .ev(ev),
        .stat_w(stat_w),
        .last_w(last_w)
    );

    pending_table #(.NI(NI), .IW(IW)) u_pend (
        .clk(MCLK),
        .rst(SRST),
        .set_all(ev.autostart_abort),
        .clr(clr_ie),
        .clr_idx(CMD_INIT),
        .pend(pend)
    );

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic is_inq, is_rs, is_tur, is_ssu, ie_hit, busy, deg;
    logic spin_deg_q, cfg_deg_q, fmt_deg_q, cfg_done_q, def_q;
    logic [15:0] def_asc_q;
    logic [7:0] code_cur, code_def;
    logic [15:0] busy_asc;

    assign is_inq = CMD_OPCODE == resp_pkg::OP_INQ;
    assign is_rs = CMD_OPCODE == resp_pkg::OP_RSENSE;
    assign is_tur = CMD_OPCODE == resp_pkg::OP_TUR;
    assign is_ssu = CMD_OPCODE == resp_pkg::OP_SSU;
    // only the asking initiator's own flag counts
    assign ie_hit = pend[CMD_INIT];
    assign busy = ctrl.startup_act || ctrl.format_act;
    assign deg = spin_deg_q || cfg_deg_q || fmt_deg_q;
    // current error code in the chosen sense format
    assign code_cur = ctrl.desc_sense ? resp_pkg::RC_CUR_DSC : resp_pkg::RC_CUR_FIX;
    assign code_def = ctrl.desc_sense ? resp_pkg::RC_DEF_DSC : resp_pkg::RC_DEF_FIX;
    // startup wins the qualifier when both run
    assign busy_asc = ctrl.startup_act ? resp_pkg::ASC_BECOMING : resp_pkg::ASC_FMT_PROG;

    // ------------------------------------------------------------
    // single decision step
    // ------------------------------------------------------------
    resp_pkg::rsp_t rsp_d, rsp_q;
    logic rsp_v_q, start_ok;

    // priority internal error, busy, degraded, deferred
    always_comb begin
        rsp_d = '{exec: 1'b1, status: resp_pkg::ST_GOOD, code: code_cur,
            key: resp_pkg::SK_NONE, asc: resp_pkg::ASC_NONE, prog: 16'h0000};
        clr_ie = 1'b0;
        clr_def = 1'b0;
        start_ok = 1'b0;
        if (!CMD_VALID) begin
            rsp_d.exec = 1'b0;
        end else if (ie_hit) begin
            if (!is_inq) begin
                rsp_d.key = resp_pkg::SK_HARDWARE;
                rsp_d.asc = resp_pkg::ASC_INTERNAL;
                clr_ie = 1'b1;
                if (!is_rs) begin
                    rsp_d.exec = 1'b0;
                    rsp_d.status = resp_pkg::ST_CHECK;
                end
            end
        end else if (busy) begin
            if (!is_inq) begin
                rsp_d.key = resp_pkg::SK_NOT_READY;
                rsp_d.asc = busy_asc;
                rsp_d.prog = ctrl.startup_act ? 16'h0000 : prog;
                if (!is_rs) begin
                    rsp_d.exec = 1'b0;
                    rsp_d.status = resp_pkg::ST_CHECK;
                end
            end
        end else if (deg) begin
            rsp_d.key = resp_pkg::SK_NOT_READY;
            rsp_d.asc = resp_pkg::ASC_INIT_REQ;
            if (is_rs) begin
                rsp_d.status = resp_pkg::ST_GOOD;
            end else if (is_inq && !CMD_VITAL_PRODUCT_PAGE_REQUEST) begin
                rsp_d.key = resp_pkg::SK_NONE;
                rsp_d.asc = resp_pkg::ASC_NONE;
            end else if (is_inq) begin
                rsp_d.status = resp_pkg::ST_CHECK;
                rsp_d.key = resp_pkg::SK_ILLEGAL;
                rsp_d.asc = resp_pkg::ASC_BAD_CDB;
            end else if (is_tur) begin
                rsp_d.status = resp_pkg::ST_CHECK;
            end else if (is_ssu && CMD_START) begin
                rsp_d.status = resp_pkg::ST_CHECK;
                unique case (ctrl.start_result)
                    resp_pkg::SR_OK: begin
                        rsp_d.status = resp_pkg::ST_GOOD;
                        rsp_d.key = resp_pkg::SK_NONE;
                        rsp_d.asc = resp_pkg::ASC_NONE;
                        start_ok = 1'b1;
                    end
                    resp_pkg::SR_SPIN: rsp_d.asc = resp_pkg::ASC_SPIN_FAIL;
                    resp_pkg::SR_BRINGUP: rsp_d.asc = resp_pkg::ASC_BRINGUP;
                    resp_pkg::SR_RAMLOAD: rsp_d.asc = resp_pkg::ASC_RAM_LOAD;
                endcase
            end else if (is_ssu) begin
                rsp_d.key = resp_pkg::SK_NONE;
                rsp_d.asc = resp_pkg::ASC_NONE;
            end else begin
                rsp_d.exec = 1'b0;
                rsp_d.status = resp_pkg::ST_CHECK;
            end
        end else if (def_q && !is_inq) begin
            rsp_d.code = code_def;
            rsp_d.key = resp_pkg::SK_MEDIUM;
            rsp_d.asc = def_asc_q;
            clr_def = 1'b1;
            if (!is_rs) begin
                rsp_d.exec = 1'b0;
                rsp_d.status = resp_pkg::ST_CHECK;
            end
        end
    end

    // response holds until the next command
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            rsp_v_q <= 1'b0;
            rsp_q <= '0;
        end else begin
            rsp_v_q <= CMD_VALID;
            if (CMD_VALID) rsp_q <= rsp_d;
        end
    end

    assign RSP_VALID = rsp_v_q;
    assign RSP_EXEC = rsp_q.exec;
    assign RSP_STATUS = rsp_q.status;
    assign RSP_CODE = rsp_q.code;
    assign RSP_KEY = rsp_q.key;
    assign RSP_ASC = rsp_q.asc;
    assign RSP_PROG = rsp_q.prog;

    // ------------------------------------------------------------
    // degraded and deferred conditions
    // ------------------------------------------------------------
    logic spin_set, spin_clr, cfg_set, fmt_set, def_set;

    assign spin_set = ev.spin_start || ev.spin_fail || (ev.stop_done && cfg_done_q);
    assign spin_clr = ev.selfcfg_ok || start_ok;
    assign cfg_set = ev.cfg_read_fail || ev.cfg_rev_mismatch;
    assign fmt_set = ev.fmt_fail && !ctrl.format_degrade_disable_bit;
    // write error counts only with caching on
    assign def_set = ev.imm_fmt_err || (ev.wce_write_err && ctrl.write_cache_on_bit);

    // set always beats clear
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            spin_deg_q <= 1'b0;
            cfg_deg_q <= 1'b0;
            fmt_deg_q <= 1'b0;
            cfg_done_q <= 1'b0;
            def_q <= 1'b0;
            def_asc_q <= resp_pkg::ASC_NONE;
        end else begin
            spin_deg_q <= spin_set || (spin_deg_q && !spin_clr);
            cfg_deg_q <= cfg_set || (cfg_deg_q && !start_ok);
            fmt_deg_q <= fmt_set || (fmt_deg_q && !ev.fmt_ok);
            cfg_done_q <= ev.selfcfg_ok || (cfg_done_q && !ev.spin_start);
            def_q <= def_set || (def_q && !clr_def);
            if (def_set) def_asc_q <= ev.imm_fmt_err ? resp_pkg::ASC_FMT_BAD : resp_pkg::ASC_WR_ERR;
        end
    end

    // status view for software
    assign stat_w = {26'h0000000, def_q, fmt_deg_q, cfg_deg_q, spin_deg_q, cfg_done_q, |pend};
    assign last_w = {rsp_q.code, rsp_q.key, 4'h0, rsp_q.asc};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_ONE_STEP: assert property (@(posedge MCLK) disable iff (SRST)
        CMD_VALID |=> RSP_VALID ##1 (RSP_VALID == $past(CMD_VALID)))
        else $error("response not one cycle after command");
    AST_BUSY_INQ: assert property (@(posedge MCLK) disable iff (SRST)
        CMD_VALID && busy && !ie_hit && is_inq |=> RSP_EXEC && RSP_STATUS == resp_pkg::ST_GOOD)
        else $error("inquiry not served while busy");
    AST_BUSY_RS: assert property (@(posedge MCLK) disable iff (SRST)
        CMD_VALID && busy && !ie_hit && is_rs |=> RSP_STATUS == resp_pkg::ST_GOOD
            && RSP_KEY == resp_pkg::SK_NOT_READY && RSP_ASC[15:8] == resp_pkg::ASC_BECOMING[15:8])
        else $error("request sense wrong while busy");
    AST_FMT_QUAL: assert property (@(posedge MCLK) disable iff (SRST)
        CMD_VALID && ctrl.format_act && !ctrl.startup_act && !ie_hit && is_rs
            |=> RSP_ASC == resp_pkg::ASC_FMT_PROG && RSP_PROG == $past(prog))
        else $error("format qualifier or progress wrong");
    AST_BUSY_OTHER: assert property (@(posedge MCLK) disable iff (SRST)
        CMD_VALID && busy && !ie_hit && !is_rs && !is_inq
            |=> !RSP_EXEC && RSP_STATUS == resp_pkg::ST_CHECK && RSP_KEY == resp_pkg::SK_NOT_READY)
        else $error("busy command not checked");
    AST_IE_ALL: assert property (@(posedge MCLK) disable iff (SRST)
        ev.autostart_abort |=> &pend)
        else $error("internal error not raised for all");
    AST_IE_SENSE: assert property (@(posedge MCLK) disable iff (SRST)
        CMD_VALID && ie_hit && is_rs |=> RSP_KEY == resp_pkg::SK_HARDWARE
            && (RSP_CODE == resp_pkg::RC_CUR_FIX || RSP_CODE == resp_pkg::RC_CUR_DSC)
            && RSP_STATUS == resp_pkg::ST_GOOD)
        else $error("internal error sense wrong");
    AST_IE_KEEP: assert property (@(posedge MCLK) disable iff (SRST)
        CMD_VALID && ie_hit && is_inq |=> pend[$past(CMD_INIT)] && RSP_STATUS == resp_pkg::ST_GOOD)
        else $error("inquiry disturbed internal error");
    AST_IE_CLEAR: assert property (@(posedge MCLK) disable iff (SRST)
        CMD_VALID && ie_hit && !is_inq && !ev.autostart_abort |=> !pend[$past(CMD_INIT)])
        else $error("internal error not cleared");
    AST_DEF_CODE: assert property (@(posedge MCLK) disable iff (SRST)
        CMD_VALID && def_q && !def_set && !ie_hit && !busy && !deg && !is_inq && !is_rs
            |=> RSP_STATUS == resp_pkg::ST_CHECK && RSP_CODE == $past(code_def) && !def_q)
        else $error("deferred error not reported");
    AST_DEG_VPD: assert property (@(posedge MCLK) disable iff (SRST)
        CMD_VALID && deg && !busy && !ie_hit && is_inq && CMD_VITAL_PRODUCT_PAGE_REQUEST
            |=> RSP_KEY == resp_pkg::SK_ILLEGAL && RSP_ASC == resp_pkg::ASC_BAD_CDB)
        else $error("vital page inquiry not refused");
    AST_DEG_TUR: assert property (@(posedge MCLK) disable iff (SRST)
        CMD_VALID && deg && !busy && !ie_hit && is_tur
            |=> RSP_STATUS == resp_pkg::ST_CHECK && RSP_ASC == resp_pkg::ASC_INIT_REQ)
        else $error("degraded tur wrong");
    AST_START_OK: assert property (@(posedge MCLK) disable iff (SRST)
        start_ok && !spin_set |=> !spin_deg_q && RSP_STATUS == resp_pkg::ST_GOOD)
        else $error("start did not clear motor degrade");
    AST_FDD_GATE: assert property (@(posedge MCLK) disable iff (SRST)
        !fmt_deg_q && ev.fmt_fail && ctrl.format_degrade_disable_bit |=> !fmt_deg_q)
        else $error("format degrade entered while disabled");
    AST_IE_RS_CLR: assert property (@(posedge MCLK) disable iff (SRST)
        CMD_VALID && ie_hit && is_rs && !ev.autostart_abort
            |=> RSP_ASC == resp_pkg::ASC_INTERNAL && !pend[$past(CMD_INIT)])
        else $error("request sense kept internal error");
    AST_DEG_RS: assert property (@(posedge MCLK) disable iff (SRST)
        CMD_VALID && deg && !busy && !ie_hit && is_rs
            |=> RSP_EXEC && RSP_STATUS == resp_pkg::ST_GOOD && RSP_ASC == resp_pkg::ASC_INIT_REQ)
        else $error("degraded request sense wrong");
    AST_START_FAIL: assert property (@(posedge MCLK) disable iff (SRST)
        CMD_VALID && deg && !busy && !ie_hit && is_ssu && CMD_START
            && ctrl.start_result != resp_pkg::SR_OK
            |=> RSP_STATUS == resp_pkg::ST_CHECK && RSP_KEY == resp_pkg::SK_NOT_READY)
        else $error("failed start not checked");
    AST_DEG_STOP: assert property (@(posedge MCLK) disable iff (SRST)
        CMD_VALID && deg && !busy && !ie_hit && is_ssu && !CMD_START && ev == '0
            |=> RSP_STATUS == resp_pkg::ST_GOOD && deg)
        else $error("degraded stop wrong");
    AST_DEG_OTHER: assert property (@(posedge MCLK) disable iff (SRST)
        CMD_VALID && deg && !busy && !ie_hit && !is_rs && !is_inq && !is_tur && !is_ssu
            |=> !RSP_EXEC && RSP_STATUS == resp_pkg::ST_CHECK
            && RSP_ASC == resp_pkg::ASC_INIT_REQ)
        else $error("degraded command executed");
    AST_DEF_SET: assert property (@(posedge MCLK) disable iff (SRST)
        ev.wce_write_err && ctrl.write_cache_on_bit && !ev.imm_fmt_err
            |=> def_q && def_asc_q == resp_pkg::ASC_WR_ERR)
        else $error("cached write error not deferred");
    AST_SPIN_SET: assert property (@(posedge MCLK) disable iff (SRST)
        ev.spin_start || ev.spin_fail |=> spin_deg_q)
        else $error("spindle degrade not entered");
    AST_CFG_SET: assert property (@(posedge MCLK) disable iff (SRST)
        ev.cfg_read_fail || ev.cfg_rev_mismatch |=> cfg_deg_q)
        else $error("configuration degrade not entered");
endmodule : not_ready_responder

// file: bench/sas_initiator_model.sv
// initiator-side command source for the responder bench
module sas_initiator_model #(
    parameter int IW = 6
) (
    // clock
    input wire logic MCLK,
    // command towards the responder
    output logic CMD_VALID,
    output logic [IW-1:0] CMD_INIT,
    output logic [7:0] CMD_OPCODE,
    output logic CMD_VITAL_PRODUCT_PAGE_REQUEST,
    output logic CMD_START
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle levels at time zero
    initial begin
        CMD_VALID = 1'b0;
        CMD_INIT = '0;
        CMD_OPCODE = 8'h00;
        CMD_VITAL_PRODUCT_PAGE_REQUEST = 1'b0;
        CMD_START = 1'b0;
    end
    // one pulse; fields inverted after it so stale values are never trusted
    task automatic send(input logic [IW-1:0] ini, input logic [7:0] op, input logic [1:0] opt);
        @(posedge MCLK);
        CMD_VALID <= 1'b1;
        CMD_INIT <= ini;
        CMD_OPCODE <= op;
        {CMD_START, CMD_VITAL_PRODUCT_PAGE_REQUEST} <= opt;
        @(posedge MCLK);
        CMD_VALID <= 1'b0;
        CMD_INIT <= ~ini;
        CMD_OPCODE <= ~op;
        {CMD_START, CMD_VITAL_PRODUCT_PAGE_REQUEST} <= ~opt;
    endtask : send
endmodule : sas_initiator_model

// file: bench/not_ready_responder_tb_top.sv
// self-checking bench for the not-ready responder
module not_ready_responder_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic MCLK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, CMD_VALID, CMD_VITAL_PRODUCT_PAGE_REQUEST, CMD_START;
    logic RSP_VALID, RSP_EXEC;
    logic [7:0] PADDR, CMD_OPCODE, code_x, RSP_STATUS, RSP_CODE;
    logic [31:0] PWDATA, PRDATA, seed;
    logic [5:0] CMD_INIT, ri, rj;
    logic [15:0] prog_x, RSP_ASC, RSP_PROG;
    logic [3:0] RSP_KEY;
    logic [1:0] k;
    resp_pkg::rsp_t rsp, e, q[$];
    int err_total, n_checks;
    not_ready_responder u_dut (.MCLK(MCLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .CMD_VALID(CMD_VALID), .CMD_INIT(CMD_INIT), .CMD_OPCODE(CMD_OPCODE),
        .CMD_VITAL_PRODUCT_PAGE_REQUEST(CMD_VITAL_PRODUCT_PAGE_REQUEST), .CMD_START(CMD_START), .RSP_VALID(RSP_VALID), .RSP_EXEC(RSP_EXEC),
        .RSP_STATUS(RSP_STATUS), .RSP_CODE(RSP_CODE), .RSP_KEY(RSP_KEY), .RSP_ASC(RSP_ASC),
        .RSP_PROG(RSP_PROG));
    // observed response as one word
    assign rsp = {RSP_EXEC, RSP_STATUS, RSP_CODE, RSP_KEY, RSP_ASC, RSP_PROG};
    sas_initiator_model u_ini (.MCLK(MCLK), .CMD_VALID(CMD_VALID), .CMD_INIT(CMD_INIT),
        .CMD_OPCODE(CMD_OPCODE), .CMD_VITAL_PRODUCT_PAGE_REQUEST(CMD_VITAL_PRODUCT_PAGE_REQUEST), .CMD_START(CMD_START));
    // 25 MHz clock
    initial begin
        MCLK = 1'b0;
        forever #20 MCLK = ~MCLK;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    // apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic er);
        int i;
        @(posedge MCLK);
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, d};
        @(posedge MCLK);
        PENABLE <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge MCLK);
            if (PREADY === 1'b1) break;
        end
        n_checks++;
        if (i == 50 || PSLVERR !== er || (!w && PRDATA !== d)) begin
            err_total++;
            $display("Error apb %h expected %h/%b seen %h/%b", a, d, er, PRDATA, PSLVERR);
            if (i == 50) wrap_up();
        end
        {PSEL, PENABLE} <= 2'b00;
    endtask : apb
    // command with expected {exec, status, key, asc}
    task automatic c(input logic [5:0] ini, input logic [7:0] op, input logic [1:0] opt,
            input logic ex, input logic [7:0] st, input logic [3:0] ky, input logic [15:0] a);
        q.push_back({ex, st, code_x, ky, a, prog_x});
        u_ini.send(ini, op, opt);
    endtask : c
    // response monitor, code ignored on keyless answers
    always @(posedge MCLK) begin
        if (RSP_VALID === 1'b1) begin
            // an unexpected response meets an impossible note
            e = q.size() != 0 ? q.pop_front() : '1;
            n_checks++;
            if (rsp !== e && !(e.key == 0 && {rsp.exec, rsp.status, rsp.key, rsp.asc,
                    rsp.prog} === {e.exec, e.status, 36'h0})) begin
                err_total++;
                $display("Error response expected %h seen %h", e, rsp);
            end
        end
    end
    initial begin
        {SRST, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {1'b1, 43'h0};
        {err_total, n_checks, seed, code_x, prog_x} = {64'h0, 32'd59781, 8'h70, 16'h0};
        repeat (20) @(posedge MCLK);
        SRST <= 1'b0;
        ri = 6'(xs());
        rj = ri ^ 6'h01;
        apb(1, 8'h00, 1, 0);
        c(ri, 8'h12, 0, 1, 8'h00, 4'h0, 16'h0);
        c(ri, 8'h03, 0, 1, 8'h00, 4'h2, 16'h0401);
        c(rj, 8'h00, 0, 0, 8'h02, 4'h2, 16'h0401);
        c(ri, 8'ha0, 0, 0, 8'h02, 4'h2, 16'h0401);
        prog_x = 16'(xs());
        apb(1, 8'h04, prog_x, 0);
        apb(1, 8'h00, 2, 0);
        c(ri, 8'h03, 0, 1, 8'h00, 4'h2, 16'h0404);
        c(rj, 8'h28, 0, 0, 8'h02, 4'h2, 16'h0404);
        prog_x = 0;
        apb(1, 8'h00, 0, 0);
        apb(1, 8'h08, 1, 0);
        apb(0, 8'h0c, 1, 0);
        apb(0, 8'h20, 0, 1);
        c(ri, 8'h12, 0, 1, 8'h00, 4'h0, 16'h0);
        c(ri, 8'h03, 0, 1, 8'h00, 4'h4, 16'h4400);
        c(ri, 8'h00, 0, 1, 8'h00, 4'h0, 16'h0);
        c(rj, 8'h00, 0, 0, 8'h02, 4'h4, 16'h4400);
        c(rj, 8'h00, 0, 1, 8'h00, 4'h0, 16'h0);
        apb(1, 8'h08, 32'h20, 0);
        c(ri, 8'h03, 0, 1, 8'h00, 4'h2, 16'h0402);
        c(ri, 8'h12, 0, 1, 8'h00, 4'h0, 16'h0);
        c(ri, 8'h12, 1, 1, 8'h02, 4'h5, 16'h2400);
        c(rj, 8'h00, 0, 1, 8'h02, 4'h2, 16'h0402);
        c(ri, 8'h1b, 0, 1, 8'h00, 4'h0, 16'h0);
        c(rj, 8'h28, 0, 0, 8'h02, 4'h2, 16'h0402);
        for (k = 1; k != 0; k++) begin
            apb(1, 8'h00, {k, 6'h0}, 0);
            c(ri, 8'h1b, 2, 1, 8'h02, 4'h2, k == 1 ? 16'h0400 : k == 2 ? 16'h4080 : 16'h4085);
        end
        apb(1, 8'h00, 0, 0);
        c(ri, 8'h1b, 2, 1, 8'h00, 4'h0, 16'h0);
        c(rj, 8'h00, 0, 1, 8'h00, 4'h0, 16'h0);
        apb(1, 8'h08, 32'h100, 0);
        code_x = 8'h71;
        c(ri, 8'h00, 0, 0, 8'h02, 4'h3, 16'h3100);
        apb(1, 8'h00, 32'h30, 0);
        apb(1, 8'h08, 32'h200, 0);
        code_x = 8'h73;
        c(rj, 8'h03, 0, 1, 8'h00, 4'h3, 16'h0c00);
        c(rj, 8'h00, 0, 1, 8'h00, 4'h0, 16'h0);
        code_x = 8'h72;
        apb(1, 8'h08, 32'h2, 0);
        c(ri, 8'h00, 0, 1, 8'h02, 4'h2, 16'h0402);
        apb(0, 8'h10, 32'h7220_0402, 0);
        apb(1, 8'h08, 32'h8, 0);
        c(ri, 8'h00, 0, 1, 8'h00, 4'h0, 16'h0);
        apb(1, 8'h08, 32'h10, 0);
        apb(0, 8'h0c, 32'h7, 0);
        apb(1, 8'h00, 32'h38, 0);
        apb(1, 8'h08, 32'h80, 0);
        apb(0, 8'h0c, 32'h7, 0);
        apb(1, 8'h00, 32'h30, 0);
        apb(1, 8'h08, 32'h80, 0);
        apb(0, 8'h0c, 32'h17, 0);
        repeat (4) @(posedge MCLK);
        if (q.size() != 0) begin
            err_total++;
            $display("Error queue expected 0 seen %0d", q.size());
        end
        wrap_up();
    end
endmodule : not_ready_responder_tb_top
